// >>> common/olmsi_defs.vh
// Constants for the optical link mode and status indicator block.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef OLMSI_DEFS_VH
`define OLMSI_DEFS_VH

// Avalon-MM register word addresses (byte address / 4)
`define OLMSI_REG_CTRL      4'h0
`define OLMSI_REG_STATUS    4'h1
`define OLMSI_REG_IRQ_STAT  4'h2
`define OLMSI_REG_IRQ_MASK  4'h3
`define OLMSI_REG_LEVEL     4'h4
`define OLMSI_ADDR_W        4

// CTRL fields
`define OLMSI_CTRL_STEP     0
`define OLMSI_CTRL_INIT     1
`define OLMSI_CTRL_RESET    32'h0000_0000

// Interrupt status / mask bits
`define OLMSI_IRQ_MODE      0
`define OLMSI_IRQ_LOSS      1
`define OLMSI_IRQ_WARN      2
`define OLMSI_IRQ_W         3

// Mode one-hot codes
`define OLMSI_M_AUTO        5'h01
`define OLMSI_M_MAN         5'h02
`define OLMSI_M_ADJ         5'h04
`define OLMSI_M_LAS         5'h08
`define OLMSI_M_CNT         5'h10

// Received level bar: 8 segments, low to high
// Segments 0..1 red, 2..3 orange, 4..7 green
`define OLMSI_LVL_W         4
`define OLMSI_LVL_ORANGE    4'h2
`define OLMSI_LVL_GREEN     4'h4

// Flash period 250 ms at 4 ns -> half period 125 ms
`define OLMSI_FLASH_HALF_MS 125
`define OLMSI_CLK_MHZ       250
`define OLMSI_FLASH_CYC     (`OLMSI_FLASH_HALF_MS * 1000 * `OLMSI_CLK_MHZ)

`endif

// >>> hw/olmsi_top.v
// Front-panel mode and status logic for one end of an infrared link.
// Assumes one 250 MHz clock, async active-low reset, Avalon-MM master.
//
// Overview of operation
// - The mode step input cycles automatic, manual, adjust, laser, counter, and exactly one mode indicator lights.
// - Automatic mode lights its indicator steadily and forwards data.
// - Automatic mode holds the link until the level falls below the last orange segment.
// - Manual mode holds the link only until the level falls below the last green segment.
// - Adjust mode stops data forwarding but holds the link down to the last orange segment.
// - Adjust mode shows the partner's received level on the local bar and sends the local level out.
// - Laser mode switches the alignment laser on and lights its indicator steadily.
// - Counter indicator is off when inactive, green with no interruption since entry, red otherwise.
// - During initialization the power indicator flashes green and no data moves.
// - After initialization with the path ready the power indicator is steady green.
// - With no green or orange segment and link broken the power indicator flashes red.
// - An intensity warning is raised while only red and orange segments show.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "olmsi_defs.vh"

module olmsi_top #(
    parameter FLASH_CYC = `OLMSI_FLASH_CYC
) (
    // Clock and reset
    input  wire                      clock,
    input  wire                      rst_b,
    // Panel and link inputs
    input  wire                      mode_button,
    input  wire [`OLMSI_LVL_W-1:0]   local_level,
    input  wire [`OLMSI_LVL_W-1:0]   remote_level,
    input  wire                      path_ready,
    // Avalon-MM slave
    input  wire [`OLMSI_ADDR_W-1:0]  avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [31:0]               avs_writedata,
    output reg  [31:0]               avs_readdata,
    output reg                       avs_waitrequest,
    // Indicators and controls
    output reg                       automatic_mode,
    output reg                       manual_mode,
    output reg                       adjust_mode,
    output reg                       laser_align_mode,
    output reg                       cnt_led_green,
    output reg                       cnt_led_red,
    output reg                       pwr_led_green,
    output reg                       pwr_led_red,
    output reg                       laser_on,
    output reg                       link_active,
    output reg                       data_forward,
    output reg  [`OLMSI_LVL_W-1:0]   level_bar,
    output reg  [`OLMSI_LVL_W-1:0]   level_to_partner,
    output reg                       intensity_warning,
    output reg                       irq
);

    // Input synchronisers
    wire                     btn_s2_q;
    wire                     rdy_s2_q;
    wire [`OLMSI_LVL_W-1:0]  loc_s2_q;
    wire [`OLMSI_LVL_W-1:0]  rem_s2_q;
    reg                      btn_s3_q;

    olmsi_sync #(
        .W (1)
    ) btn_sync_i (
        .clock  (clock),
        .rst_b  (rst_b),
        .d_in   (mode_button),
        .sync_q (btn_s2_q)
    );

    olmsi_sync #(
        .W (1)
    ) rdy_sync_i (
        .clock  (clock),
        .rst_b  (rst_b),
        .d_in   (path_ready),
        .sync_q (rdy_s2_q)
    );

    olmsi_sync #(
        .W (`OLMSI_LVL_W)
    ) loc_sync_i (
        .clock  (clock),
        .rst_b  (rst_b),
        .d_in   (local_level),
        .sync_q (loc_s2_q)
    );

    olmsi_sync #(
        .W (`OLMSI_LVL_W)
    ) rem_sync_i (
        .clock  (clock),
        .rst_b  (rst_b),
        .d_in   (remote_level),
        .sync_q (rem_s2_q)
    );

    // Button history for rising edge detection
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            btn_s3_q <= 1'b0;
        end else begin
            btn_s3_q <= btn_s2_q;
        end
    end

    // Registers
    reg [31:0]               ctrl_q;
    reg [`OLMSI_IRQ_W-1:0]   irq_stat_q;
    reg [`OLMSI_IRQ_W-1:0]   irq_mask_q;
    reg [4:0]                mode_q;
    reg [4:0]                mode_d;
    reg                      lost_q;
    reg                      link_q;
    reg                      warn_q;
    reg [31:0]               flash_cnt_q;
    reg                      flash_q;

    // Bus access strobes
    // Writes land at the edge where the master sees waitrequest low
    wire bus_wr   = avs_write && !avs_waitrequest;
    wire bus_rd   = avs_read && avs_waitrequest;
    wire sw_step  = bus_wr && (avs_address == `OLMSI_REG_CTRL) &&
                    avs_writedata[`OLMSI_CTRL_STEP];
    wire btn_rise = btn_s2_q && !btn_s3_q;
    wire step     = btn_rise || sw_step;
    wire init_done = ctrl_q[`OLMSI_CTRL_INIT];

    // Mode sequence
    always @* begin
        case (mode_q)
            `OLMSI_M_AUTO: mode_d = `OLMSI_M_MAN;
            `OLMSI_M_MAN:  mode_d = `OLMSI_M_ADJ;
            `OLMSI_M_ADJ:  mode_d = `OLMSI_M_LAS;
            `OLMSI_M_LAS:  mode_d = `OLMSI_M_CNT;
            `OLMSI_M_CNT:  mode_d = `OLMSI_M_AUTO;
            default:       mode_d = `OLMSI_M_AUTO;
        endcase
    end

    // Link hold threshold per mode
    wire [`OLMSI_LVL_W-1:0] hold_lvl =
        (mode_q == `OLMSI_M_MAN) ? `OLMSI_LVL_GREEN :
                                   `OLMSI_LVL_ORANGE;
    wire link_d  = init_done && rdy_s2_q && (loc_s2_q >= hold_lvl);
    wire warn_d  = (loc_s2_q < `OLMSI_LVL_GREEN);
    wire broken  = (loc_s2_q < `OLMSI_LVL_ORANGE) && !link_q;
    wire entering_cnt = step && (mode_d == `OLMSI_M_CNT);

    wire [`OLMSI_IRQ_W-1:0] irq_set;
    assign irq_set[`OLMSI_IRQ_MODE] = step;
    assign irq_set[`OLMSI_IRQ_LOSS] = link_q && !link_d;
    assign irq_set[`OLMSI_IRQ_WARN] = warn_d && !warn_q;

    // Core state
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_q      <= `OLMSI_M_AUTO;
            lost_q      <= 1'b0;
            link_q      <= 1'b0;
            warn_q      <= 1'b0;
        end else begin
            if (step)
                mode_q <= mode_d;
            if (entering_cnt)
                lost_q <= 1'b0;
            else if (mode_q == `OLMSI_M_CNT && link_q && !link_d)
                lost_q <= 1'b1;
            link_q <= link_d;
            warn_q <= warn_d;
        end
    end

    // Flash timebase shared by both power indicator colours
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flash_cnt_q <= 32'h0000_0000;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q >= FLASH_CYC - 1) begin
            flash_cnt_q <= 32'h0000_0000;
            flash_q     <= !flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
        end
    end

    // Indicators and controls
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            automatic_mode    <= 1'b0;
            manual_mode       <= 1'b0;
            adjust_mode       <= 1'b0;
            laser_align_mode  <= 1'b0;
            cnt_led_green     <= 1'b0;
            cnt_led_red       <= 1'b0;
            laser_on          <= 1'b0;
            link_active       <= 1'b0;
            data_forward      <= 1'b0;
            level_bar         <= {`OLMSI_LVL_W{1'b0}};
            level_to_partner  <= {`OLMSI_LVL_W{1'b0}};
            intensity_warning <= 1'b0;
        end else begin
            automatic_mode   <= (mode_q == `OLMSI_M_AUTO);
            manual_mode      <= (mode_q == `OLMSI_M_MAN);
            adjust_mode      <= (mode_q == `OLMSI_M_ADJ);
            laser_align_mode <= (mode_q == `OLMSI_M_LAS);
            laser_on         <= (mode_q == `OLMSI_M_LAS);
            cnt_led_green    <= (mode_q == `OLMSI_M_CNT) && !lost_q;
            cnt_led_red      <= (mode_q == `OLMSI_M_CNT) && lost_q;
            link_active      <= link_q;
            // No data while initializing, none in adjust mode
            data_forward     <= link_q && init_done &&
                                (mode_q != `OLMSI_M_ADJ);
            level_bar        <= (mode_q == `OLMSI_M_ADJ) ?
                                rem_s2_q : loc_s2_q;
            level_to_partner <= loc_s2_q;
            intensity_warning <= warn_q;
        end
    end

    // Power indicator
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwr_led_green <= 1'b0;
            pwr_led_red   <= 1'b0;
        end else if (!init_done) begin
            pwr_led_green <= flash_q;
            pwr_led_red   <= 1'b0;
        end else if (broken) begin
            pwr_led_green <= 1'b0;
            pwr_led_red   <= flash_q;
        end else begin
            pwr_led_green <= rdy_s2_q;
            pwr_led_red   <= 1'b0;
        end
    end

    // Avalon-MM slave: one wait cycle, then answer
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) &&
                                 avs_waitrequest);
        end
    end

    // Control register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `OLMSI_CTRL_RESET;
        end else if (bus_wr && avs_address == `OLMSI_REG_CTRL) begin
            ctrl_q <= {31'h0000_0000,
                       avs_writedata[`OLMSI_CTRL_INIT]} <<
                      `OLMSI_CTRL_INIT;
        end
    end

    // Interrupt mask
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_q <= {`OLMSI_IRQ_W{1'b0}};
        end else if (bus_wr && avs_address == `OLMSI_REG_IRQ_MASK) begin
            irq_mask_q <= avs_writedata[`OLMSI_IRQ_W-1:0];
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= {`OLMSI_IRQ_W{1'b0}};
        end else if (bus_wr && avs_address == `OLMSI_REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q &
                           ~avs_writedata[`OLMSI_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Interrupt line
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data, loaded while the request waits so it stands at the answer
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (avs_address)
                `OLMSI_REG_CTRL:
                    avs_readdata <= ctrl_q;
                `OLMSI_REG_STATUS:
                    avs_readdata <= {22'h000000, rdy_s2_q, warn_q,
                                     lost_q, link_q, 1'b0, mode_q};
                `OLMSI_REG_IRQ_STAT:
                    avs_readdata <= {29'h00000000, irq_stat_q};
                `OLMSI_REG_IRQ_MASK:
                    avs_readdata <= {29'h00000000, irq_mask_q};
                `OLMSI_REG_LEVEL:
                    avs_readdata <= {24'h000000, rem_s2_q, loc_s2_q};
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // olmsi_top

// Two-flip-flop synchroniser for pin inputs
module olmsi_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire          clock,
    input  wire          rst_b,
    // Data
    input  wire [W-1:0]  d_in,
    output reg  [W-1:0]  sync_q
);

    reg [W-1:0]          meta_q;

    // First stage is read only by the second
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

endmodule // olmsi_sync

// >>> test/olmsi_props.sv
// Concurrent checks on the panel block's ports.
// Assumes one clock domain; bound to every olmsi_top instance.
`timescale 1ns/1ps
module olmsi_props (
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // Bus handshake
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    // Indicators
    input logic automatic_mode,
    input logic manual_mode,
    input logic adjust_mode,
    input logic laser_align_mode,
    input logic cnt_led_green,
    input logic cnt_led_red,
    input logic pwr_led_green,
    input logic pwr_led_red,
    input logic laser_on,
    input logic data_forward
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic cnt_on;
    assign cnt_on = cnt_led_green | cnt_led_red;

    AST_ONE_MODE: assert property ($onehot0({automatic_mode,
        manual_mode, adjust_mode, laser_align_mode, cnt_on}))
        else $error("more than one mode indicator lit");
    AST_LASER: assert property (laser_on == laser_align_mode)
        else $error("laser drive differs from laser mode");
    AST_CNT_TWO: assert property (!(cnt_led_green && cnt_led_red))
        else $error("counter indicator green and red together");
    AST_NO_FWD: assert property (adjust_mode && $past(adjust_mode)
        |-> !data_forward) else $error("data forwarded in adjust mode");
    AST_WAIT_LOW: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer longer than one cycle");
    AST_PWR_ONE: assert property (!(pwr_led_green && pwr_led_red))
        else $error("power indicator green and red together");
    AST_CNT_RED: assert property ($past(cnt_led_red) && cnt_on
        |-> cnt_led_red) else $error("interruption flag lost");
    cover property (laser_on);
    cover property (cnt_led_red);
    cover property (pwr_led_red);
endmodule // olmsi_props

bind olmsi_top olmsi_props olmsi_props_i (.clock, .rst_b, .avs_read,
    .avs_write, .avs_waitrequest, .automatic_mode, .manual_mode,
    .adjust_mode, .laser_align_mode, .cnt_led_green, .cnt_led_red,
    .pwr_led_green, .pwr_led_red, .laser_on, .data_forward);

// >>> test/olmsi_partner.sv
// Model of the opposing link device.
// Assumes the bench sets its own measured level.
`timescale 1ns/1ps
module olmsi_partner (
    // Clock
    input  logic       clock,
    // Levels
    input  logic [3:0] own_level,
    input  logic [3:0] rx_level,
    output logic [3:0] remote_level,
    output logic [3:0] shown_level
);
    // Send own level, show what arrives
    always @(posedge clock) begin
        remote_level <= own_level;
        shown_level  <= rx_level;
    end
endmodule // olmsi_partner

// >>> test/olmsi_top_tb_top.sv
// Self-checking bench for the panel block.
// Assumes olmsi_props is bound and the partner model is present.
`timescale 1ns/1ps
module olmsi_top_tb_top;
    logic        clock, rst_b, mode_button, path_ready, avs_read;
    logic        avs_write, avs_waitrequest, automatic_mode, manual_mode;
    logic        adjust_mode, laser_align_mode, cnt_led_green, cnt_led_red;
    logic        pwr_led_green, pwr_led_red, laser_on, link_active;
    logic        data_forward, intensity_warning, irq;
    logic [3:0]  local_level, remote_level, own_level, avs_address;
    logic [3:0]  level_bar, level_to_partner, shown;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [2:0]  v;
    logic [4:0]  mt [5] = '{5'h08, 5'h04, 5'h03, 5'h00, 5'h10};
    int          errors, check_count, cyc;

    olmsi_top #(.FLASH_CYC(4)) olmsi_top_i (.clock, .rst_b, .mode_button,
        .local_level, .remote_level, .path_ready, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .automatic_mode, .manual_mode, .adjust_mode, .laser_align_mode,
        .cnt_led_green, .cnt_led_red, .pwr_led_green, .pwr_led_red,
        .laser_on, .link_active, .data_forward, .level_bar,
        .level_to_partner, .intensity_warning, .irq);
    olmsi_partner olmsi_partner_i (.clock, .own_level, .remote_level,
        .rx_level(level_to_partner), .shown_level(shown));

    task chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task step;
        mode_button <= 1'b1;
        wt(6);
        mode_button <= 1'b0;
        wt(8);
    endtask
    task lvl(input logic [3:0] l);
        local_level <= l;
        wt(8);
    endtask
    // Green seen, green always, red seen over twelve cycles
    task fl;
        v = 3'b010;
        repeat (12) begin
            @(posedge clock);
            v = v | {pwr_led_green, 1'b0, pwr_led_red};
            v[1] = v[1] & pwr_led_green;
        end
    endtask
    task t_modes;
        chk("auto", automatic_mode, 1'b1);
        for (int i = 0; i < 5; i++) begin
            step;
            chk("mode", {automatic_mode, manual_mode, adjust_mode,
                laser_align_mode, laser_on}, mt[i]);
            chk("cnt", cnt_led_green | cnt_led_red, i == 3);
        end
        $display("modes done");
    endtask
    task t_init;
        lvl(4'h8);
        fl;
        chk("pwr", v, 3'h4);
        chk("fwd", data_forward, 1'b0);
        bus(1'b0, 4'h0, 32'h2);
        wt(6);
        fl;
        chk("pwr", v, 3'h6);
        chk("link", link_active, 1'b1);
        chk("fwd", data_forward, 1'b1);
        path_ready <= 1'b0;
        wt(6);
        fl;
        chk("pwr", v, 3'h0);
        chk("link", link_active, 1'b0);
        path_ready <= 1'b1;
        wt(6);
        $display("init done");
    endtask
    task t_levels;
        lvl(4'h3);
        chk("link", link_active, 1'b1);
        chk("warn", intensity_warning, 1'b1);
        lvl(4'h4);
        chk("warn", intensity_warning, 1'b0);
        lvl(4'h1);
        chk("link", link_active, 1'b0);
        fl;
        chk("pwr", v, 3'h1);
        step;
        chk("link", link_active, 1'b0);
        lvl(4'h3);
        chk("link", link_active, 1'b0);
        lvl(4'h4);
        chk("link", link_active, 1'b1);
        $display("levels done");
    endtask
    task t_adjust;
        step;
        own_level <= 4'h9;
        lvl(4'h2);
        chk("link", link_active, 1'b1);
        chk("fwd", data_forward, 1'b0);
        chk("bar", level_bar, 4'h9);
        chk("sent", shown, 4'h2);
        $display("adjust done");
    endtask
    task t_count;
        step;
        step;
        lvl(4'h8);
        chk("cnt", {cnt_led_green, cnt_led_red}, 2'b10);
        lvl(4'h0);
        chk("cnt", {cnt_led_green, cnt_led_red}, 2'b01);
        lvl(4'h8);
        chk("cnt", {cnt_led_green, cnt_led_red}, 2'b01);
        repeat (5) step;
        chk("cnt", {cnt_led_green, cnt_led_red}, 2'b10);
        $display("counter done");
    endtask
    task t_irq;
        bus(1'b0, 4'h2, 32'h7);
        bus(1'b0, 4'h3, 32'h1);
        wt(3);
        chk("irq", irq, 1'b0);
        bus(1'b0, 4'h0, 32'h3);
        wt(3);
        chk("irq", irq, 1'b1);
        chk("auto", automatic_mode, 1'b1);
        bus(1'b1, 4'h2, 32'h0);
        chk("stat", q[0], 1'b1);
        bus(1'b0, 4'h2, 32'h1);
        wt(3);
        chk("irq", irq, 1'b0);
        bus(1'b1, 4'hF, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("irq done");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        {rst_b, mode_button, avs_read, avs_write} = 4'h0;
        {local_level, own_level, avs_address} = 12'h000;
        {avs_writedata, cyc, path_ready} = {64'h0, 1'b1};
        wt(8);
        rst_b <= 1'b1;
        wt(4);
        t_modes;
        t_init;
        t_levels;
        t_adjust;
        t_count;
        t_irq;
        report_and_stop;
    end
endmodule // olmsi_top_tb_top
